// >>> verilog/ueirq_consts.vh
// Constants of the USB event interrupt request block: register offsets,
// field positions, reset values and vector codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UEIRQ_CONSTS_VH
`define UEIRQ_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses on the 16-bit register port)
`define UEIRQ_ADDR_IN_REQ 16'h7fa9
`define UEIRQ_ADDR_OUT_REQ 16'h7faa
`define UEIRQ_ADDR_BUS_REQ 16'h7fab
`define UEIRQ_ADDR_IN_EN 16'h7fac
`define UEIRQ_ADDR_OUT_EN 16'h7fad
`define UEIRQ_ADDR_BUS_EN 16'h7fae
`define UEIRQ_ADDR_NAK_REQ 16'h7fb0
`define UEIRQ_ADDR_NAK_EN 16'h7fb1
`define UEIRQ_ADDR_VECTOR 16'h7fa8

// ==========================================================
// Bus event field positions
`define UEIRQ_BIT_SETUP_DATA 0
`define UEIRQ_BIT_FRAME_START 1
`define UEIRQ_BIT_SETUP_TOKEN 2
`define UEIRQ_BIT_SUSPEND 3
`define UEIRQ_BIT_BUS_RESET 4
`define UEIRQ_BIT_BULK_NAK 5
`define UEIRQ_BUS_MASK 8'h3f
`define UEIRQ_NAK_MASK 8'h7f

// ==========================================================
// Reset values
`define UEIRQ_RST_REQ 8'h00
`define UEIRQ_RST_EN 8'h00
`define UEIRQ_RST_VEC 8'h00

// ==========================================================
// Vector codes: bus events 0..5, IN endpoints 6..13, OUT endpoints 14..21
`define UEIRQ_VEC_IN_BASE 5'h06
`define UEIRQ_VEC_OUT_BASE 5'h0e

`endif

// >>> verilog/ueirq_edge_fall.v
// Falling edge detector for the eight endpoint busy flags.
// Assumes busy flags come from logic on SYS_CLK, so no synchroniser is used.
module ueirq_edge_fall (
  input wire clk,
  input wire srst,
  input wire [7:0] busy,
  output wire [7:0] fell
);
  reg [7:0] busy_d_ff;

  // ==========================================================
  // Delayed copy of busy; reset as not busy so no false edge
  always @(posedge clk) begin
    if (srst) begin
      busy_d_ff <= 8'h00;
    end else begin
      busy_d_ff <= busy;
    end
  end

  // Pulse when busy went from one to zero
  assign fell = busy_d_ff & ~busy;
endmodule

// >>> verilog/ueirq_top.v
// Interrupt request and enable logic of a USB peripheral controller.
// Assumes event strobes and busy flags are one-cycle / level signals from
// logic on SYS_CLK; SRST is the power-on reset; CPU_RST is the core reset.
//
// Added by the designer: the strobed register port.
`include "ueirq_consts.vh"

module ueirq_top (
  input wire SYS_CLK,
  input wire SRST,
  input wire CPU_RST,
  input wire [15:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [7:0] IN_BUSY,
  input wire [7:0] OUT_BUSY,
  input wire [6:0] BULK_IN_NAK,
  input wire BUS_RESET_EVT,
  input wire SUSPEND_EVT,
  input wire SETUP_TOKEN_EVT,
  input wire FRAME_START_EVT,
  input wire SETUP_DATA_EVT,
  output reg USB_INT
);
  reg [7:0] in_req_ff;
  reg [7:0] out_req_ff;
  reg [7:0] bus_req_ff;
  reg [7:0] nak_req_ff;
  reg [7:0] in_en_ff;
  reg [7:0] out_en_ff;
  reg [7:0] bus_en_ff;
  reg [7:0] nak_en_ff;
  reg [7:0] vec_ff;
  reg [7:0] nxt_in_req;
  reg [7:0] nxt_out_req;
  reg [7:0] nxt_bus_req;
  reg [7:0] nxt_nak_req;
  reg [7:0] nxt_rdata;
  reg [7:0] nxt_vec;
  reg nxt_int;
  reg [7:0] bus_set;
  reg [7:0] bus_act;
  wire [7:0] in_fell;
  wire [7:0] out_fell;
  wire [7:0] in_act;
  wire [7:0] out_act;
  wire nak_sum;
  wire [7:0] nak_act;
  // Write strobes per register
  wire wr_in_req;
  wire wr_out_req;
  wire wr_bus_req;
  wire wr_nak_req;
  wire wr_in_en;
  wire wr_out_en;
  wire wr_bus_en;
  wire wr_nak_en;

  // ==========================================================
  // Request update: set wins over write-one clear
  function [7:0] req_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    input hit;
    begin
      req_next = (cur & ~(hit ? clr : 8'h00)) | set;
    end
  endfunction

  // Lowest set bit index, 3 bits
  function [2:0] low_idx;
    input [7:0] v;
    integer i;
    begin
      low_idx = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          low_idx = i[2:0];
        end
      end
    end
  endfunction

  // Pack a five-bit source code into the vector byte layout
  function [7:0] vec_code;
    input [4:0] code;
    begin
      vec_code = {1'b0, code, 2'b00};
    end
  endfunction

  // Register address compare, shared by every write decode
  function addr_hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  // ==========================================================
  // Busy falling edge detectors for IN and OUT endpoints
  ueirq_edge_fall u_in_fall (
    .clk(SYS_CLK),
    .srst(SRST),
    .busy(IN_BUSY),
    .fell(in_fell)
  );

  ueirq_edge_fall u_out_fall (
    .clk(SYS_CLK),
    .srst(SRST),
    .busy(OUT_BUSY),
    .fell(out_fell)
  );

  // ==========================================================
  // Write decodes; one strobe reaches one register at most
  assign wr_in_req = WR & addr_hit(ADDR, `UEIRQ_ADDR_IN_REQ);
  assign wr_out_req = WR & addr_hit(ADDR, `UEIRQ_ADDR_OUT_REQ);
  assign wr_bus_req = WR & addr_hit(ADDR, `UEIRQ_ADDR_BUS_REQ);
  assign wr_nak_req = WR & addr_hit(ADDR, `UEIRQ_ADDR_NAK_REQ);
  assign wr_in_en = WR & addr_hit(ADDR, `UEIRQ_ADDR_IN_EN);
  assign wr_out_en = WR & addr_hit(ADDR, `UEIRQ_ADDR_OUT_EN);
  assign wr_bus_en = WR & addr_hit(ADDR, `UEIRQ_ADDR_BUS_EN);
  assign wr_nak_en = WR & addr_hit(ADDR, `UEIRQ_ADDR_NAK_EN);

  // ==========================================================
  // Gated request terms; enables touch only the line and the source vector
  assign in_act = in_req_ff & in_en_ff;
  assign out_act = out_req_ff & out_en_ff;
  // Per-endpoint NAK terms need their own enable first
  assign nak_act = nak_req_ff & nak_en_ff;
  // Summary gate sits over all per-endpoint NAK terms
  assign nak_sum = bus_en_ff[`UEIRQ_BIT_BULK_NAK] & |nak_act;

  // Bus event set vector and gating
  always @* begin
    bus_set = 8'h00;
    bus_set[`UEIRQ_BIT_BULK_NAK] = |BULK_IN_NAK;
    bus_set[`UEIRQ_BIT_BUS_RESET] = BUS_RESET_EVT;
    bus_set[`UEIRQ_BIT_SUSPEND] = SUSPEND_EVT;
    bus_set[`UEIRQ_BIT_SETUP_TOKEN] = SETUP_TOKEN_EVT;
    bus_set[`UEIRQ_BIT_FRAME_START] = FRAME_START_EVT;
    bus_set[`UEIRQ_BIT_SETUP_DATA] = SETUP_DATA_EVT;
    bus_act = bus_req_ff & bus_en_ff & `UEIRQ_BUS_MASK;
    bus_act[`UEIRQ_BIT_BULK_NAK] = bus_req_ff[`UEIRQ_BIT_BULK_NAK] & bus_en_ff[`UEIRQ_BIT_BULK_NAK];
  end

  // ==========================================================
  // Next request values; held regardless of enables
  always @* begin
    nxt_in_req = req_next(in_req_ff, in_fell, WDATA, wr_in_req);
    nxt_out_req = req_next(out_req_ff, out_fell, WDATA, wr_out_req);
    // Reserved bits 7:6 never latch
    nxt_bus_req = req_next(bus_req_ff, bus_set, WDATA, wr_bus_req) & `UEIRQ_BUS_MASK;
    // Only endpoints zero to six can NAK, bit 7 stays clear
    nxt_nak_req = req_next(nak_req_ff, {1'b0, BULK_IN_NAK}, WDATA, wr_nak_req) & `UEIRQ_NAK_MASK;
  end

  // ==========================================================
  // Combined line and source vector, priority bus events first
  always @* begin
    nxt_int = |in_act | |out_act | |bus_act | nak_sum;
    nxt_vec = vec_ff;
    if (|bus_act) begin
      nxt_vec = vec_code({2'b00, low_idx(bus_act)});
    end else if (|in_act) begin
      nxt_vec = vec_code(`UEIRQ_VEC_IN_BASE + {2'b00, low_idx(in_act)});
    end else if (|out_act) begin
      nxt_vec = vec_code(`UEIRQ_VEC_OUT_BASE + {2'b00, low_idx(out_act)});
    end else if (nak_sum) begin
      // Per-endpoint NAK shares the bulk NAK code
      nxt_vec = vec_code(5'h05);
    end
  end

  // ==========================================================
  // Read data decode, valid the cycle after the read strobe
  always @* begin
    nxt_rdata = 8'h00;
    if (ADDR == `UEIRQ_ADDR_IN_REQ) begin
      nxt_rdata = in_req_ff;
    end else if (ADDR == `UEIRQ_ADDR_OUT_REQ) begin
      nxt_rdata = out_req_ff;
    end else if (ADDR == `UEIRQ_ADDR_BUS_REQ) begin
      nxt_rdata = bus_req_ff;
    end else if (ADDR == `UEIRQ_ADDR_IN_EN) begin
      nxt_rdata = in_en_ff;
    end else if (ADDR == `UEIRQ_ADDR_OUT_EN) begin
      nxt_rdata = out_en_ff;
    end else if (ADDR == `UEIRQ_ADDR_BUS_EN) begin
      nxt_rdata = bus_en_ff;
    end else if (ADDR == `UEIRQ_ADDR_NAK_REQ) begin
      nxt_rdata = nak_req_ff;
    end else if (ADDR == `UEIRQ_ADDR_NAK_EN) begin
      nxt_rdata = nak_en_ff;
    end else if (ADDR == `UEIRQ_ADDR_VECTOR) begin
      nxt_rdata = vec_ff;
    end
  end

  // ==========================================================
  // IN endpoint request flags; only power-on reset clears them
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      in_req_ff <= `UEIRQ_RST_REQ;
    end else begin
      in_req_ff <= nxt_in_req;
    end
  end

  // OUT endpoint request flags; only power-on reset clears them
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      out_req_ff <= `UEIRQ_RST_REQ;
    end else begin
      out_req_ff <= nxt_out_req;
    end
  end

  // Bus event flags keep running while the core sits in reset
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      bus_req_ff <= `UEIRQ_RST_REQ;
    end else begin
      bus_req_ff <= nxt_bus_req;
    end
  end

  // Per-endpoint NAK flags; only power-on reset clears them
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      nak_req_ff <= `UEIRQ_RST_REQ;
    end else begin
      nak_req_ff <= nxt_nak_req;
    end
  end

  // ==========================================================
  // Enable registers; core reset returns them to zero
  always @(posedge SYS_CLK) begin
    if (SRST || CPU_RST) begin
      in_en_ff <= `UEIRQ_RST_EN;
      out_en_ff <= `UEIRQ_RST_EN;
      bus_en_ff <= `UEIRQ_RST_EN;
      nak_en_ff <= `UEIRQ_RST_EN;
    end else begin
      if (wr_in_en) begin
        in_en_ff <= WDATA;
      end
      if (wr_out_en) begin
        out_en_ff <= WDATA;
      end
      // Reserved enable bits read back as zero
      if (wr_bus_en) begin
        bus_en_ff <= WDATA & `UEIRQ_BUS_MASK;
      end
      if (wr_nak_en) begin
        nak_en_ff <= WDATA & `UEIRQ_NAK_MASK;
      end
    end
  end

  // ==========================================================
  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? nxt_rdata : 8'h00;
    end
  end

  // Combined request line, registered so it never glitches
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      USB_INT <= 1'b0;
    end else begin
      USB_INT <= nxt_int;
    end
  end

  // Source vector, held while no enabled source is pending
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      vec_ff <= `UEIRQ_RST_VEC;
    end else begin
      vec_ff <= nxt_vec;
    end
  end
endmodule

// >>> testbench/ueirq_assertions.sv
// Port checker for the USB event interrupt block.
// Assumes binding to ueirq_top and the register map of ueirq_consts.vh.
`include "ueirq_consts.vh"
module ueirq_assertions (
  input wire SYS_CLK,
  input wire SRST,
  input wire [15:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire [7:0] IN_BUSY,
  input wire [7:0] OUT_BUSY,
  input wire [6:0] BULK_IN_NAK,
  input wire BUS_RESET_EVT,
  input wire SUSPEND_EVT,
  input wire SETUP_TOKEN_EVT,
  input wire FRAME_START_EVT,
  input wire SETUP_DATA_EVT,
  input wire USB_INT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Event strobes in bus request bit order
  wire [5:0] ev = {|BULK_IN_NAK, BUS_RESET_EVT, SUSPEND_EVT, SETUP_TOKEN_EVT, FRAME_START_EVT, SETUP_DATA_EVT};
  wire rd_bus = RD && ADDR == `UEIRQ_ADDR_BUS_REQ;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  chk_reset_quiet: assert property ($fell(SRST) |-> !USB_INT && RDATA == 8'h00)
    else $error("outputs up after reset");
  chk_unmapped_read: assert property (RD && ADDR[15:8] != 8'h7f |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_bus_reserved: assert property (rd_bus |=> RDATA[7:6] == 2'b00)
    else $error("reserved request bits set");
  chk_vector_form: assert property (RD && ADDR == `UEIRQ_ADDR_VECTOR |=> RDATA[7] == 1'b0 && RDATA[1:0] == 2'b00)
    else $error("vector format wrong");
  chk_event_latch: assert property (rd_bus |=> ($past(ev, 2) & ~RDATA[5:0]) == 6'h00)
    else $error("event not latched");
  chk_clear_one: assert property ((WR && ADDR == `UEIRQ_ADDR_BUS_REQ && ev == 6'h00) ##1 ev == 6'h00 ##1 rd_bus
    |=> (RDATA & $past(WDATA, 3)) == 8'h00) else $error("write one did not clear");
  chk_in_fall: assert property (RD && ADDR == `UEIRQ_ADDR_IN_REQ |=> ($past(IN_BUSY, 4) & ~$past(IN_BUSY, 3) & ~RDATA) == 8'h00)
    else $error("IN request missing");
  chk_out_fall: assert property (RD && ADDR == `UEIRQ_ADDR_OUT_REQ |=> ($past(OUT_BUSY, 4) & ~$past(OUT_BUSY, 3) & ~RDATA) == 8'h00)
    else $error("OUT request missing");
  cover property (BUS_RESET_EVT ##2 USB_INT);
  cover property ($fell(IN_BUSY[2]));
  cover property ($fell(USB_INT));
endmodule
bind ueirq_top ueirq_assertions u_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .IN_BUSY(IN_BUSY), .OUT_BUSY(OUT_BUSY), .BULK_IN_NAK(BULK_IN_NAK), .BUS_RESET_EVT(BUS_RESET_EVT),
  .SUSPEND_EVT(SUSPEND_EVT), .SETUP_TOKEN_EVT(SETUP_TOKEN_EVT), .FRAME_START_EVT(FRAME_START_EVT),
  .SETUP_DATA_EVT(SETUP_DATA_EVT), .USB_INT(USB_INT));

// >>> testbench/ueirq_core_model.sv
// Processor core stand-in: counts the USB interrupts it takes.
// Assumes the request line is a level on the same clock.
module ueirq_core_model (
  input wire clk,
  input wire srst,
  input wire usb_int,
  input wire usb_line_enable,
  input wire global_interrupt_enable,
  output reg [7:0] taken_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  reg int_q_ff;
  // ==========
  // Entry on a rising line, only with both core enables set
  always @(posedge clk) begin
    int_q_ff <= usb_int;
    if (srst)
      taken_ff <= 8'h00;
    else if (usb_int && !int_q_ff && usb_line_enable && global_interrupt_enable)
      taken_ff <= taken_ff + 8'h01;
  end
endmodule

// >>> testbench/test_usb_event_interrupt_requests.sv
// Self-checking bench for the USB event interrupt block.
// Assumes ueirq_top, its checker and ueirq_core_model are compiled first.
`include "ueirq_consts.vh"
module test_usb_event_interrupt_requests;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, cpu_rst = 0, wr = 0, rd = 0, glob = 1;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, in_busy = 8'hff, out_busy = 8'hff, rdata, taken;
  logic [6:0] nak = 0;
  logic [4:0] evt = 0;
  logic usb_int;
  int error_cnt = 0, compares = 0, cyc = 0, i;
  ueirq_top uut (.SYS_CLK(clk), .SRST(srst), .CPU_RST(cpu_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IN_BUSY(in_busy), .OUT_BUSY(out_busy), .BULK_IN_NAK(nak), .BUS_RESET_EVT(evt[4]),
    .SUSPEND_EVT(evt[3]), .SETUP_TOKEN_EVT(evt[2]), .FRAME_START_EVT(evt[1]), .SETUP_DATA_EVT(evt[0]),
    .USB_INT(usb_int));
  ueirq_core_model core (.clk(clk), .srst(srst), .usb_int(usb_int), .usb_line_enable(glob),
    .global_interrupt_enable(glob), .taken_ff(taken));
  // ==========
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end
  // Compare, bus cycles and event strobes
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic line_is(input logic [7:0] e);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, usb_int}, e);
    @(posedge clk);
  endtask
  task automatic pulse(input int b);
    if (b == 5)
      nak <= 7'h08;
    else
      evt <= 5'h01 << b;
    @(posedge clk);
    nak <= 0;
    evt <= 0;
  endtask
  task automatic test_done;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    for (i = 16'h7fa8; i <= 16'h7fb1; i++)
      rd_reg(i[15:0], 8'h00);
    rd_reg(16'h0000, 8'h00);
    for (i = 0; i < 6; i++) begin
      pulse(i);
      rd_reg(`UEIRQ_ADDR_BUS_REQ, (8'h02 << i) - 8'h01);
    end
    line_is(8'h00);
    for (i = 0; i < 6; i++) begin
      wr_reg(`UEIRQ_ADDR_BUS_REQ, 8'h01 << i);
      rd_reg(`UEIRQ_ADDR_BUS_REQ, 8'h3f & ~((8'h02 << i) - 8'h01));
    end
    wr_reg(`UEIRQ_ADDR_BUS_EN, 8'h10);
    // Bus reset arrives on the very edge that clears it
    addr <= `UEIRQ_ADDR_BUS_REQ;
    wdata <= 8'h10;
    wr <= 1;
    evt <= 5'h10;
    @(posedge clk);
    wr <= 0;
    evt <= 0;
    line_is(8'h01);
    rd_reg(`UEIRQ_ADDR_VECTOR, 8'h10);
    chk(taken, 8'h01);
    wr_reg(`UEIRQ_ADDR_BUS_REQ, 8'h10);
    line_is(8'h00);
    // Endpoints hand buffers back while their enables are off
    in_busy <= 8'hfb;
    repeat (3) @(posedge clk);
    rd_reg(`UEIRQ_ADDR_IN_REQ, 8'h04);
    out_busy <= 8'h7f;
    repeat (3) @(posedge clk);
    rd_reg(`UEIRQ_ADDR_OUT_REQ, 8'h80);
    line_is(8'h00);
    wr_reg(`UEIRQ_ADDR_OUT_EN, 8'h80);
    line_is(8'h01);
    rd_reg(`UEIRQ_ADDR_VECTOR, 8'h54);
    wr_reg(`UEIRQ_ADDR_OUT_REQ, 8'h80);
    line_is(8'h00);
    // Per-endpoint bulk NAK request behind the summary gate
    wr_reg(`UEIRQ_ADDR_NAK_EN, 8'h08);
    line_is(8'h00);
    wr_reg(`UEIRQ_ADDR_BUS_EN, 8'h20);
    line_is(8'h01);
    rd_reg(`UEIRQ_ADDR_VECTOR, 8'h14);
    rd_reg(`UEIRQ_ADDR_NAK_REQ, 8'h08);
    wr_reg(`UEIRQ_ADDR_NAK_REQ, 8'h08);
    line_is(8'h00);
    // Core reset keeps event flags alive; power-on reset clears them
    cpu_rst <= 1;
    pulse(3);
    rd_reg(`UEIRQ_ADDR_BUS_REQ, 8'h08);
    rd_reg(`UEIRQ_ADDR_BUS_EN, 8'h00);
    cpu_rst <= 0;
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd_reg(`UEIRQ_ADDR_BUS_REQ, 8'h00);
    test_done;
  end
endmodule
